// >>> include/dcf_params.svh
// Constants shared by the FIFO device end and its controller
`ifndef DCF_PARAMS_SVH
`define DCF_PARAMS_SVH

// Storage geometry
`define DCF_DW          36
`define DCF_AW          10
`define DCF_WORDS       1024
`define DCF_DEPTH       11'h400
`define DCF_HALF        11'h200

// Default almost-empty / almost-full offset pairs, index {sel_b, sel_a, load}
`define DCF_DEF_OFS0    10'h007
`define DCF_DEF_OFS1    10'h00F
`define DCF_DEF_OFS2    10'h01F
`define DCF_DEF_OFS3    10'h03F
`define DCF_DEF_OFS4    10'h07F
`define DCF_DEF_OFS5    10'h0FF
`define DCF_DEF_OFS6    10'h1FF
`define DCF_DEF_OFS7    10'h3FE

// Controller register byte offsets
`define DCF_REG_CTRL    5'h00
`define DCF_REG_CMD     5'h04
`define DCF_REG_WDLO    5'h08
`define DCF_REG_WDHI    5'h0C
`define DCF_REG_RDLO    5'h10
`define DCF_REG_RDHI    5'h14
`define DCF_REG_STAT    5'h18

// CTRL fields
`define DCF_CTRL_FT     0
`define DCF_CTRL_SYNC   1
`define DCF_CTRL_SELA   2
`define DCF_CTRL_SELB   3
`define DCF_CTRL_LOAD   4
`define DCF_CTRL_RST    32'h0000_0010

// CMD fields
`define DCF_CMD_MRST    0
`define DCF_CMD_PRST    1
`define DCF_CMD_PUSH    2
`define DCF_CMD_POP     3
`define DCF_CMD_OWR     4
`define DCF_CMD_ORD     5
`define DCF_CMD_SER     6
`define DCF_CMD_SBIT    7

// Cycles that master or partial reset is held low
`define DCF_RST_CYCLES  3'h4

`endif

// >>> include/dcf_pkg.sv
// Types shared by the FIFO device end and its controller
package dcf_pkg;
  typedef logic [35:0] dcf_word_t;
  typedef logic [10:0] dcf_ptr_t;
  typedef logic [9:0]  dcf_ofs_t;

  typedef enum logic [1:0] {
    CTL_IDLE    = 2'b00,
    CTL_RESET   = 2'b01,
    CTL_STROBE  = 2'b10,
    CTL_CAPTURE = 2'b11
  } dcf_ctl_state_e;
endpackage : dcf_pkg

// >>> include/dcf_if.sv
// Pin-level link between the FIFO device end and its controller
`timescale 1ns/1ps
interface dcf_if;
  import dcf_pkg::*;
  dcf_word_t data_in_bus;
  dcf_word_t data_out_bus;
  logic      write_n;
  logic      read_n;
  logic      offset_load_n;
  logic      serial_load_enable_n;
  logic      mode_or_serial_pin;
  logic      default_offset_sel_a;
  logic      default_offset_sel_b;
  logic      flag_timing_select;
  logic      master_reset_n;
  logic      partial_reset_n;
  logic      empty_flag_n;
  logic      full_flag_n;
  logic      half_full_flag_n;
  logic      almost_empty_flag_n;
  logic      almost_full_flag_n;

  modport dev (
    input  data_in_bus, write_n, read_n, offset_load_n, serial_load_enable_n,
    input  mode_or_serial_pin, default_offset_sel_a, default_offset_sel_b,
    input  flag_timing_select, master_reset_n, partial_reset_n,
    output data_out_bus, empty_flag_n, full_flag_n, half_full_flag_n,
    output almost_empty_flag_n, almost_full_flag_n
  );

  modport ctl (
    output data_in_bus, write_n, read_n, offset_load_n, serial_load_enable_n,
    output mode_or_serial_pin, default_offset_sel_a, default_offset_sel_b,
    output flag_timing_select, master_reset_n, partial_reset_n,
    input  data_out_bus, empty_flag_n, full_flag_n, half_full_flag_n,
    input  almost_empty_flag_n, almost_full_flag_n
  );
endinterface : dcf_if

// >>> verilog/dcf_flag_gen.sv
// Status flag generation for the FIFO device end
`timescale 1ns/1ps
`include "dcf_params.svh"
module dcf_flag_gen (
  input  wire logic           ref_clk_i,
  input  wire logic           rst_i,
  input  wire logic           in_reset_i,
  input  wire logic           ft_mode_i,
  input  wire logic           sync_flags_i,
  input  wire logic           out_valid_i,
  input  wire dcf_pkg::dcf_ptr_t used_mem_i,
  input  wire dcf_pkg::dcf_ptr_t used_all_i,
  input  wire dcf_pkg::dcf_ofs_t ae_ofs_i,
  input  wire dcf_pkg::dcf_ofs_t af_ofs_i,
  output logic                ef_or_n_o,
  output logic                ff_ir_n_o,
  output logic                hf_n_o,
  output logic                ae_n_o,
  output logic                af_n_o
);
  import dcf_pkg::*;

  dcf_ptr_t free_all;
  logic     ae_now;
  logic     af_now;
  logic     ae_r;
  logic     af_r;

  assign free_all = `DCF_DEPTH - used_all_i;
  assign ae_now   = used_all_i <= {1'b0, ae_ofs_i};
  assign af_now   = free_all <= {1'b0, af_ofs_i};

  // Shared pins change meaning with the timing mode
  assign ef_or_n_o = ft_mode_i ? ~out_valid_i : (used_all_i != 11'h000);
  assign ff_ir_n_o = ft_mode_i ? (used_mem_i == `DCF_DEPTH)
                               : (used_mem_i != `DCF_DEPTH);
  assign hf_n_o    = ~(used_all_i > `DCF_HALF);

  // Synchronous mode samples on the clock edge only
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ae_r <= 1'b0;
      af_r <= 1'b1;
    end else if (in_reset_i) begin
      ae_r <= 1'b0;
      af_r <= 1'b1;
    end else begin
      ae_r <= ~ae_now;
      af_r <= ~af_now;
    end
  end

  // Asynchronous mode follows the counts in the same cycle as the pointer move
  assign ae_n_o = sync_flags_i ? ae_r : ~ae_now;
  assign af_n_o = sync_flags_i ? af_r : ~af_now;
endmodule : dcf_flag_gen

// >>> verilog/dcf_fifo_dev.sv
// Device end of the FIFO: storage, output timing, offsets and resets
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "dcf_params.svh"

// Contract
// - Fall-through shows first word; later words need strobe
// - Mode pin sampled at master reset, fixed
// - Fall-through outputs chain straight into next buffer
// - Five status flags are driven
// - Shared flags: empty/full or output/input ready
// - Half, almost-empty, almost-full in both modes
// - Two independent offsets anywhere in depth
// - Predefined offset pairs are provided
// - Default pair picked from pins during master reset
// - Serial enable plus load shifts one bit
// - Write strobe plus load loads offset from bus
// - Read strobe plus load shows offsets on output
// - Master reset clears pointers, latches mode
// - Partial reset clears pointers, keeps mode and offsets
// - Flags recomputed after partial reset
// - Almost flags have synchronous and asynchronous behaviour
// - Fall-through word appears after three clock edges
// - Standard word appears only on read strobe
// - Synchronous almost flags change on clock edges
// - Asynchronous almost flags follow pointer moves directly
module dcf_fifo_dev (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  dcf_if.dev        link,
  output logic      ft_mode_o,
  output logic      sync_flags_o
);
  import dcf_pkg::*;

  dcf_word_t mem [0:`DCF_WORDS-1];

  dcf_ptr_t  wr_ptr_r;
  dcf_ptr_t  wr_seen_r;
  dcf_ptr_t  rd_ptr_r;
  dcf_word_t dout_r;
  logic      out_valid_r;
  logic      ft_mode_r;
  logic      sync_flags_r;
  dcf_ofs_t  ae_ofs_r;
  dcf_ofs_t  af_ofs_r;
  logic      load_sel_r;
  logic      rb_sel_r;

  logic      in_reset;
  logic      room;
  logic      mem_avail;
  logic      wr_req;
  logic      rd_strobe;
  logic      rb_req;
  logic      pop_mem;
  dcf_ptr_t  used_mem;
  dcf_ptr_t  used_seen;
  dcf_ptr_t  used_all;
  logic      ser_shift;
  logic      par_load;

  // Default pair table, index {sel_b, sel_a, load}
  function automatic dcf_ofs_t def_ofs(input logic [2:0] idx);
    case (idx)
      3'h0:    def_ofs = `DCF_DEF_OFS0;
      3'h1:    def_ofs = `DCF_DEF_OFS1;
      3'h2:    def_ofs = `DCF_DEF_OFS2;
      3'h3:    def_ofs = `DCF_DEF_OFS3;
      3'h4:    def_ofs = `DCF_DEF_OFS4;
      3'h5:    def_ofs = `DCF_DEF_OFS5;
      3'h6:    def_ofs = `DCF_DEF_OFS6;
      3'h7:    def_ofs = `DCF_DEF_OFS7;
      default: def_ofs = `DCF_DEF_OFS0;
    endcase
  endfunction : def_ofs

  assign in_reset  = ~link.master_reset_n | ~link.partial_reset_n;
  assign used_mem  = wr_ptr_r - rd_ptr_r;
  assign used_seen = wr_seen_r - rd_ptr_r;
  assign used_all  = used_mem + {10'h000, ft_mode_r & out_valid_r};
  assign room      = used_mem != `DCF_DEPTH;
  assign mem_avail = used_seen != 11'h000;

  // Offset access is steered by the load pin; data traffic needs it high
  assign wr_req    = ~in_reset & ~link.write_n & link.offset_load_n & room;
  assign rd_strobe = ~in_reset & ~link.read_n & link.offset_load_n;
  assign rb_req    = ~in_reset & ~link.read_n & ~link.offset_load_n;
  assign ser_shift = ~in_reset & ~link.serial_load_enable_n & ~link.offset_load_n;
  assign par_load  = ~in_reset & ~link.write_n & ~link.offset_load_n & link.serial_load_enable_n;

  // Fall-through refills an empty output stage unprompted
  assign pop_mem = mem_avail & (ft_mode_r ? (~out_valid_r | rd_strobe)
                                          : rd_strobe);

  // Storage holds no reset so it maps onto plain RAM
  always_ff @(posedge ref_clk_i) begin
    if (wr_req) begin
      mem[wr_ptr_r[`DCF_AW-1:0]] <= link.data_in_bus;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_r <= 11'h000;
    end else if (in_reset) begin
      wr_ptr_r <= 11'h000;
    end else if (wr_req) begin
      wr_ptr_r <= wr_ptr_r + 11'h001;
    end
  end

  // One-cycle delay of the write pointer toward the read side
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_seen_r <= 11'h000;
    end else if (in_reset) begin
      wr_seen_r <= 11'h000;
    end else begin
      wr_seen_r <= wr_ptr_r;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_ptr_r <= 11'h000;
    end else if (in_reset) begin
      rd_ptr_r <= 11'h000;
    end else if (pop_mem) begin
      rd_ptr_r <= rd_ptr_r + 11'h001;
    end
  end

  // Output register; readback of offsets takes priority over data
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dout_r <= 36'h0_0000_0000;
    end else if (rb_req) begin
      dout_r <= {26'h000_0000, rb_sel_r ? af_ofs_r : ae_ofs_r};
    end else if (pop_mem) begin
      dout_r <= mem[rd_ptr_r[`DCF_AW-1:0]];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_valid_r <= 1'b0;
    end else if (in_reset) begin
      out_valid_r <= 1'b0;
    end else if (pop_mem) begin
      out_valid_r <= 1'b1;
    end else if (rd_strobe) begin
      out_valid_r <= 1'b0;
    end
  end

  // Mode pins are caught while master reset is low; partial reset leaves them
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ft_mode_r    <= 1'b0;
      sync_flags_r <= 1'b0;
    end else if (~link.master_reset_n) begin
      ft_mode_r    <= link.mode_or_serial_pin;
      sync_flags_r <= link.flag_timing_select;
    end
  end

  // Offsets: default at master reset, else serial shift or parallel load
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ae_ofs_r <= `DCF_DEF_OFS0;
      af_ofs_r <= `DCF_DEF_OFS0;
    end else if (~link.master_reset_n) begin
      ae_ofs_r <= def_ofs({link.default_offset_sel_b, link.default_offset_sel_a,
                           link.offset_load_n});
      af_ofs_r <= def_ofs({link.default_offset_sel_b, link.default_offset_sel_a,
                           link.offset_load_n});
    end else if (ser_shift) begin
      // Almost-empty offset is loaded first, most significant bit first
      {ae_ofs_r, af_ofs_r} <= {ae_ofs_r[`DCF_AW-2:0], af_ofs_r,
                               link.mode_or_serial_pin};
    end else if (par_load) begin
      if (load_sel_r) begin
        af_ofs_r <= link.data_in_bus[`DCF_AW-1:0];
      end else begin
        ae_ofs_r <= link.data_in_bus[`DCF_AW-1:0];
      end
    end
  end

  // Parallel load and readback alternate almost-empty, then almost-full
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      load_sel_r <= 1'b0;
    end else if (in_reset) begin
      load_sel_r <= 1'b0;
    end else if (par_load) begin
      load_sel_r <= ~load_sel_r;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rb_sel_r <= 1'b0;
    end else if (in_reset) begin
      rb_sel_r <= 1'b0;
    end else if (rb_req) begin
      rb_sel_r <= ~rb_sel_r;
    end
  end

  dcf_flag_gen u_flags (
    .ref_clk_i    (ref_clk_i),
    .rst_i        (rst_i),
    .in_reset_i   (in_reset),
    .ft_mode_i    (ft_mode_r),
    .sync_flags_i (sync_flags_r),
    .out_valid_i  (out_valid_r),
    .used_mem_i   (used_mem),
    .used_all_i   (used_all),
    .ae_ofs_i     (ae_ofs_r),
    .af_ofs_i     (af_ofs_r),
    .ef_or_n_o    (link.empty_flag_n),
    .ff_ir_n_o    (link.full_flag_n),
    .hf_n_o       (link.half_full_flag_n),
    .ae_n_o       (link.almost_empty_flag_n),
    .af_n_o       (link.almost_full_flag_n)
  );

  // Registered output feeds the next stage's input bus with no glue
  assign link.data_out_bus = dout_r;
  assign ft_mode_o         = ft_mode_r;
  assign sync_flags_o      = sync_flags_r;
endmodule : dcf_fifo_dev

// >>> verilog/dcf_fifo_ctl.sv
// Controller end of the FIFO: Avalon-MM registers driving the FIFO pins
`timescale 1ns/1ps
`include "dcf_params.svh"
module dcf_fifo_ctl (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  dcf_if.ctl               link
);
  import dcf_pkg::*;

  dcf_ctl_state_e state_r;
  logic [31:0]    ctrl_r;
  dcf_word_t      wdata_r;
  dcf_word_t      rdata_r;
  logic [31:0]    readdata_r;
  logic           ack_r;
  logic [2:0]     cnt_r;
  logic [7:0]     cmd_r;
  logic           write_n_r;
  logic           read_n_r;
  logic           load_n_r;
  logic           sen_n_r;
  logic           si_r;
  logic           mrs_n_r;
  logic           prs_n_r;
  logic           wr_take;
  logic           cmd_take;
  logic [31:0]    rd_mux;

  // One wait cycle per access; busy commands hold off every access
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign avs_readdata_o    = readdata_r;
  assign wr_take           = avs_write_i & ack_r;
  assign cmd_take          = wr_take & (avs_address_i == `DCF_REG_CMD);

  always_comb begin
    case (avs_address_i)
      `DCF_REG_CTRL: rd_mux = ctrl_r;
      `DCF_REG_WDLO: rd_mux = wdata_r[31:0];
      `DCF_REG_WDHI: rd_mux = {28'h000_0000, wdata_r[35:32]};
      `DCF_REG_RDLO: rd_mux = rdata_r[31:0];
      `DCF_REG_RDHI: rd_mux = {28'h000_0000, rdata_r[35:32]};
      `DCF_REG_STAT: rd_mux = {26'h000_0000, state_r != CTL_IDLE,
                               link.almost_full_flag_n, link.almost_empty_flag_n,
                               link.half_full_flag_n, link.full_flag_n,
                               link.empty_flag_n};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r      <= 1'b0;
      readdata_r <= 32'h0000_0000;
    end else begin
      ack_r      <= (avs_read_i | avs_write_i) & ~ack_r & (state_r == CTL_IDLE);
      readdata_r <= rd_mux;
    end
  end

  // Settings only change while idle, so reset-time pins stay steady
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r  <= `DCF_CTRL_RST;
      wdata_r <= 36'h0_0000_0000;
    end else if (wr_take) begin
      case (avs_address_i)
        `DCF_REG_CTRL: ctrl_r <= avs_writedata_i;
        `DCF_REG_WDLO: wdata_r[31:0] <= avs_writedata_i;
        `DCF_REG_WDHI: wdata_r[35:32] <= avs_writedata_i[3:0];
        default:       ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Command sequencer; lowest command bit set wins
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= CTL_IDLE;
      cmd_r   <= 8'h00;
      cnt_r   <= 3'h0;
    end else begin
      case (state_r)
        CTL_IDLE: begin
          if (cmd_take) begin
            cmd_r   <= avs_writedata_i[7:0];
            cnt_r   <= `DCF_RST_CYCLES;
            state_r <= (avs_writedata_i[`DCF_CMD_MRST] | avs_writedata_i[`DCF_CMD_PRST])
                       ? CTL_RESET : CTL_STROBE;
          end
        end
        CTL_RESET: begin
          cnt_r <= cnt_r - 3'h1;
          if (cnt_r == 3'h1) begin
            state_r <= CTL_IDLE;
          end
        end
        CTL_STROBE: begin
          state_r <= ((~ctrl_r[`DCF_CTRL_FT] & cmd_r[`DCF_CMD_POP]) | cmd_r[`DCF_CMD_ORD])
                     ? CTL_CAPTURE : CTL_IDLE;
        end
        CTL_CAPTURE: state_r <= CTL_IDLE;
        default:     state_r <= CTL_IDLE;
      endcase
    end
  end

  // Pin drivers follow the next state so each strobe lasts one cycle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      write_n_r <= 1'b1;
      read_n_r  <= 1'b1;
      load_n_r  <= 1'b1;
      sen_n_r   <= 1'b1;
      si_r      <= 1'b0;
      mrs_n_r   <= 1'b1;
      prs_n_r   <= 1'b1;
    end else begin
      write_n_r <= 1'b1;
      read_n_r  <= 1'b1;
      sen_n_r   <= 1'b1;
      load_n_r  <= 1'b1;
      si_r      <= ctrl_r[`DCF_CTRL_FT];
      mrs_n_r   <= 1'b1;
      prs_n_r   <= 1'b1;
      if (state_r == CTL_IDLE && cmd_take) begin
        if (avs_writedata_i[`DCF_CMD_MRST]) begin
          mrs_n_r  <= 1'b0;
          load_n_r <= ctrl_r[`DCF_CTRL_LOAD];
        end else if (avs_writedata_i[`DCF_CMD_PRST]) begin
          prs_n_r <= 1'b0;
        end else if (avs_writedata_i[`DCF_CMD_PUSH]) begin
          write_n_r <= 1'b0;
        end else if (avs_writedata_i[`DCF_CMD_POP]) begin
          read_n_r <= 1'b0;
        end else if (avs_writedata_i[`DCF_CMD_OWR]) begin
          write_n_r <= 1'b0;
          load_n_r  <= 1'b0;
        end else if (avs_writedata_i[`DCF_CMD_ORD]) begin
          read_n_r <= 1'b0;
          load_n_r <= 1'b0;
        end else if (avs_writedata_i[`DCF_CMD_SER]) begin
          sen_n_r  <= 1'b0;
          load_n_r <= 1'b0;
          si_r     <= avs_writedata_i[`DCF_CMD_SBIT];
        end
      end else if (state_r == CTL_RESET && cnt_r != 3'h1) begin
        load_n_r <= cmd_r[`DCF_CMD_MRST] ? ctrl_r[`DCF_CTRL_LOAD] : 1'b1;
        mrs_n_r  <= ~cmd_r[`DCF_CMD_MRST];
        prs_n_r  <= cmd_r[`DCF_CMD_MRST];
      end
    end
  end

  // Fall-through data is already shown, so it is taken as the pop is issued
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 36'h0_0000_0000;
    end else if (state_r == CTL_IDLE && cmd_take && ctrl_r[`DCF_CTRL_FT]
                 && avs_writedata_i[`DCF_CMD_POP] && ~avs_writedata_i[`DCF_CMD_MRST]
                 && ~avs_writedata_i[`DCF_CMD_PRST] && ~avs_writedata_i[`DCF_CMD_PUSH]) begin
      rdata_r <= link.data_out_bus;
    end else if (state_r == CTL_CAPTURE) begin
      rdata_r <= link.data_out_bus;
    end
  end

  assign link.data_in_bus          = wdata_r;
  assign link.write_n              = write_n_r;
  assign link.read_n               = read_n_r;
  assign link.offset_load_n        = load_n_r;
  assign link.serial_load_enable_n = sen_n_r;
  assign link.mode_or_serial_pin   = si_r;
  assign link.default_offset_sel_a = ctrl_r[`DCF_CTRL_SELA];
  assign link.default_offset_sel_b = ctrl_r[`DCF_CTRL_SELB];
  assign link.flag_timing_select   = ctrl_r[`DCF_CTRL_SYNC];
  assign link.master_reset_n       = mrs_n_r;
  assign link.partial_reset_n      = prs_n_r;
endmodule : dcf_fifo_ctl

// >>> tb/dcf_link_props.sv
// Concurrent checks on the pins between the FIFO controller and device
`timescale 1ns/1ps
module dcf_link_props
  import dcf_pkg::*;
(
  input wire logic      ref_clk_i,
  input wire logic      rst_i,
  input wire dcf_word_t data_in_bus,
  input wire dcf_word_t data_out_bus,
  input wire logic      write_n,
  input wire logic      read_n,
  input wire logic      offset_load_n,
  input wire logic      serial_load_enable_n,
  input wire logic      mode_or_serial_pin,
  input wire logic      default_offset_sel_a,
  input wire logic      default_offset_sel_b,
  input wire logic      flag_timing_select,
  input wire logic      master_reset_n,
  input wire logic      partial_reset_n,
  input wire logic      empty_flag_n,
  input wire logic      full_flag_n,
  input wire logic      half_full_flag_n,
  input wire logic      almost_empty_flag_n,
  input wire logic      almost_full_flag_n
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic ft_r;
  logic run;
  logic std_async;
  assign run = master_reset_n & partial_reset_n;
  // Registered almost flags lag a cycle and FT mode reuses the shared flags, so flag relations are checked in standard async mode only
  assign std_async = !ft_r & !flag_timing_select;
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i) ft_r <= 1'b0;
    else if (!master_reset_n) ft_r <= mode_or_serial_pin;
  reset_flags_a:
    assert property ($rose(run) |-> empty_flag_n == ft_r && full_flag_n == !ft_r
      && half_full_flag_n && almost_full_flag_n) else $error("flags wrong after reset");
  ft_first_word_a:
    assert property (ft_r && run && !write_n && offset_load_n && empty_flag_n |-> ##3
      !empty_flag_n && data_out_bus == $past(data_in_bus, 3)) else $error("first word late");
  std_hold_a:
    assert property (!ft_r && run && read_n |=> $stable(data_out_bus))
      else $error("output moved without strobe");
  ft_hold_a:
    assert property (ft_r && run && read_n && !empty_flag_n |=> $stable(data_out_bus)
      && !empty_flag_n) else $error("word not held");
  one_strobe_a:
    assert property ($onehot0({~write_n, ~read_n, ~serial_load_enable_n}))
      else $error("two strobes at once");
  strobe_pulse_a:
    assert property (!read_n || !write_n |=> read_n && write_n) else $error("strobe too long");
  rst_len_a:
    assert property ($fell(master_reset_n) |-> !master_reset_n [*3] ##[1:3] master_reset_n)
      else $error("reset length wrong");
  pins_steady_a:
    assert property (!master_reset_n && !$past(master_reset_n) |-> $stable({default_offset_sel_a,
      default_offset_sel_b, offset_load_n, mode_or_serial_pin, flag_timing_select}))
      else $error("select pins moved in reset");
  full_flags_a:
    assert property (std_async && !full_flag_n |-> !half_full_flag_n && !almost_full_flag_n)
      else $error("flags wrong when full");
  empty_flags_a:
    assert property (std_async && !empty_flag_n |-> !almost_empty_flag_n && half_full_flag_n
      && full_flag_n) else $error("flags wrong when empty");
endmodule : dcf_link_props

// >>> tb/dual_clock_fifo_flag_offset_control_tb.sv
// Self-checking bench driving the controller registers over Avalon-MM
`timescale 1ns/1ps
`include "dcf_params.svh"
module dual_clock_fifo_flag_offset_control_tb;
  import dcf_pkg::*;
  logic        ref_clk_i;
  logic        rst_i;
  logic [4:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [31:0] q;
  logic        ft_mode;
  logic        sync_flags;
  int          failures = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  localparam dcf_ofs_t DEF [8] = '{`DCF_DEF_OFS0, `DCF_DEF_OFS1, `DCF_DEF_OFS2, `DCF_DEF_OFS3,
    `DCF_DEF_OFS4, `DCF_DEF_OFS5, `DCF_DEF_OFS6, `DCF_DEF_OFS7};
  localparam logic [19:0] SER = 20'h5_A9C3;
  dcf_if lk ();
  dcf_fifo_dev i_dcf_fifo_dev (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(lk),
    .ft_mode_o(ft_mode), .sync_flags_o(sync_flags));
  dcf_fifo_ctl i_dcf_fifo_ctl (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(lk),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o));
  dcf_link_props i_dcf_link_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .data_in_bus(lk.data_in_bus), .data_out_bus(lk.data_out_bus), .write_n(lk.write_n),
    .read_n(lk.read_n), .offset_load_n(lk.offset_load_n), .serial_load_enable_n(lk.serial_load_enable_n),
    .mode_or_serial_pin(lk.mode_or_serial_pin), .default_offset_sel_a(lk.default_offset_sel_a),
    .default_offset_sel_b(lk.default_offset_sel_b), .flag_timing_select(lk.flag_timing_select),
    .master_reset_n(lk.master_reset_n), .partial_reset_n(lk.partial_reset_n),
    .empty_flag_n(lk.empty_flag_n), .full_flag_n(lk.full_flag_n),
    .half_full_flag_n(lk.half_full_flag_n), .almost_empty_flag_n(lk.almost_empty_flag_n),
    .almost_full_flag_n(lk.almost_full_flag_n));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Request holds until an edge sees waitrequest low; a hang ends at the bench timeout
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge ref_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : av
  task automatic cmd(input int b);
    av(1'b1, `DCF_REG_CMD, 32'h0000_0001 << b);
  endtask : cmd
  task automatic push(input logic [31:0] d);
    av(1'b1, `DCF_REG_WDLO, d);
    cmd(`DCF_CMD_PUSH);
  endtask : push
  task automatic pop_chk(input logic [31:0] exp);
    cmd(`DCF_CMD_POP);
    av(1'b0, `DCF_REG_RDLO, 32'h0);
    check("pop data", q, exp);
  endtask : pop_chk
  task automatic stat_chk(input logic [4:0] exp);
    av(1'b0, `DCF_REG_STAT, 32'h0);
    check("status", q & 32'h0000_003F, {27'h0, exp});
  endtask : stat_chk
  task automatic ofs_chk(input dcf_ofs_t ae, input dcf_ofs_t af);
    cmd(`DCF_CMD_ORD);
    av(1'b0, `DCF_REG_RDLO, 32'h0);
    check("ae offset", q & 32'h0000_03FF, {22'h0, ae});
    cmd(`DCF_CMD_ORD);
    av(1'b0, `DCF_REG_RDLO, 32'h0);
    check("af offset", q & 32'h0000_03FF, {22'h0, af});
  endtask : ofs_chk
  task automatic stop_test();
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    rst_i = 1'b1;
    avs_address_i = 5'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0000_0000;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    av(1'b0, `DCF_REG_CTRL, 32'h0);
    check("ctrl reset", q, `DCF_CTRL_RST);
    stat_chk(5'h16);
    av(1'b0, 5'h1C, 32'h0);
    check("unmapped", q, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      av(1'b1, `DCF_REG_CTRL, {27'h0, i[0], i[2:1], 2'b00});
      cmd(`DCF_CMD_MRST);
      ofs_chk(DEF[i], DEF[i]);
    end
    cmd(`DCF_CMD_PRST);
    push(32'h0000_0123);
    for (int j = 0; j < 2; j++) begin
      av(1'b1, `DCF_REG_WDLO, j ? 32'h0000_02A5 : 32'h0000_0123);
      av(1'b1, `DCF_REG_CMD, 32'h0000_0001 << `DCF_CMD_OWR);
    end
    cmd(`DCF_CMD_PRST);
    ofs_chk(10'h123, 10'h2A5);
    for (int b = 19; b >= 0; b--) av(1'b1, `DCF_REG_CMD, {24'h0, SER[b], 7'h40});
    cmd(`DCF_CMD_PRST);
    ofs_chk(SER[19:10], SER[9:0]);
    stat_chk(5'h16);
    av(1'b1, `DCF_REG_CTRL, 32'h0000_0000);
    cmd(`DCF_CMD_MRST);
    for (int k = 1; k <= 1024; k++) begin
      push(32'(k));
      stat_chk({1024 - k > 7, k > 7, k <= 512, k < 1024, 1'b1});
    end
    push(32'h0000_0BAD);
    for (int k = 1; k <= 1024; k++) pop_chk(32'(k));
    stat_chk(5'h16);
    check("mode", {30'h0, ft_mode, sync_flags}, 32'h0000_0000);
    av(1'b1, `DCF_REG_CTRL, 32'h0000_0003);
    cmd(`DCF_CMD_MRST);
    stat_chk(5'h15);
    check("mode", {30'h0, ft_mode, sync_flags}, 32'h0000_0003);
    push(32'h0000_0A01);
    cmd(`DCF_CMD_PRST);
    stat_chk(5'h15);
    check("mode kept", {30'h0, ft_mode, sync_flags}, 32'h0000_0003);
    push(32'h0000_0A02);
    push(32'h0000_0A03);
    pop_chk(32'h0000_0A02);
    pop_chk(32'h0000_0A03);
    stat_chk(5'h15);
    stop_test();
  end
endmodule : dual_clock_fifo_flag_offset_control_tb
